/* hdl/hmon_pkg.sv */
`default_nettype none

package hmon_pkg;

  // ==========================================================
  // Host port selects
  // ==========================================================
  localparam logic [2:0] HMON_PORT_INDEX = 3'h5;
  localparam logic [2:0] HMON_PORT_DATA = 3'h6;

  // ==========================================================
  // Register indexes behind the data port
  // ==========================================================
  localparam logic [6:0] HMON_IX_TEMP1 = 7'h27;
  localparam logic [6:0] HMON_IX_CFG = 7'h40;
  localparam logic [6:0] HMON_IX_ST1 = 7'h41;
  localparam logic [6:0] HMON_IX_ST2 = 7'h42;
  localparam logic [6:0] HMON_IX_SMI1 = 7'h43;
  localparam logic [6:0] HMON_IX_SMI2 = 7'h44;
  localparam logic [6:0] HMON_IX_NMI1 = 7'h45;
  localparam logic [6:0] HMON_IX_NMI2 = 7'h46;
  localparam logic [6:0] HMON_IX_FANDIV = 7'h47;
  localparam logic [6:0] HMON_IX_SERADR = 7'h48;
  localparam logic [6:0] HMON_IX_TEMP_HI = 7'h50;
  localparam logic [6:0] HMON_IX_TEMP_LO = 7'h51;
  localparam logic [6:0] HMON_IX_SCR_END = 7'h1f;
  localparam logic [6:0] HMON_IX_VRAM_BEGIN = 7'h60;
  localparam logic [6:0] HMON_IX_VRAM_END = 7'h7f;

  // ==========================================================
  // Reset values and the sensor 2 bank number
  // ==========================================================
  localparam logic [7:0] HMON_RST_ZERO = 8'h00;
  localparam logic [7:0] HMON_RST_CFG = 8'h01;
  localparam logic [7:0] HMON_RST_NMI2 = 8'h20;
  localparam logic [3:0] HMON_RST_FANDIV = 4'h5;
  localparam logic [6:0] HMON_RST_SERADR = 7'h2d;
  localparam logic [2:0] HMON_BANK_T2 = 3'h1;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int HMON_CFG_SRST = 7;
  localparam int HMON_CFG_TONE = 6;
  localparam int HMON_CFG_HALT = 3;
  localparam int HMON_CFG_SMIEN = 1;
  localparam int HMON_CFG_START = 0;
  localparam int HMON_ST1_T1 = 4;
  localparam int HMON_ST1_T2 = 5;
  localparam int HMON_ST2_T3 = 5;
  localparam int HMON_BUSY = 7;

  // Hysteresis value that selects comparator mode on sensor 1
  localparam logic [7:0] HMON_CMP_HYST = 8'h7f;

endpackage

`default_nettype wire

/* hdl/hmon_alarm_if.sv */
`default_nettype none

interface hmon_alarm_if #(
  parameter int W = 9
);
  logic signed [W-1:0] temp;
  logic signed [W-1:0] over;
  logic signed [W-1:0] hyst;
  logic conv;
  logic rel_at_over;
  logic two_times;
  logic ovt_int_mode;
  logic int_clear;
  logic ovt_clear;
  logic soft_clr;
  logic event_p;
  logic ovt_on;

  modport ctl (
    output temp, over, hyst, conv, rel_at_over, two_times,
    output ovt_int_mode, int_clear, ovt_clear, soft_clr,
    input event_p, ovt_on
  );
  modport snr (
    input temp, over, hyst, conv, rel_at_over, two_times,
    input ovt_int_mode, int_clear, ovt_clear, soft_clr,
    output event_p, ovt_on
  );
endinterface

`default_nettype wire

/* hdl/hmon_temp_alarm.sv */
`default_nettype none

module hmon_temp_alarm #(
  parameter int W = 9
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  hmon_alarm_if.snr a
);

  if (W < 8 || W > 9) begin : g_chk
    $error("hmon_temp_alarm: W must be 8 or 9");
  end

  typedef enum {HMON_COOL, HMON_HOT} hmon_heat_e;

  hmon_heat_e state;
  hmon_heat_e next_state;
  logic int_ack;
  logic ovt_ack;
  logic ovt_latch;
  logic evt;

  // ==========================================================
  // Threshold decode
  // ==========================================================
  wire logic above = a.temp > a.over;
  wire logic below_rel = a.rel_at_over ? (a.temp < a.over) :
                                         (a.temp < a.hyst);
  wire logic is_hot = state == HMON_HOT;
  wire logic rise = a.conv && !is_hot && above;
  wire logic fall = a.conv && is_hot && below_rel;
  // Status bit stays set while uncleared, so re-raising is harmless
  wire logic cmp_evt = a.conv && (above || (is_hot && !below_rel));
  wire logic two_evt = rise || (fall && int_ack);
  wire logic next_evt = a.two_times ? two_evt : cmp_evt;

  always_comb begin
    next_state = state;
    case (state)
      HMON_COOL: begin
        if (rise) begin
          next_state = HMON_HOT;
        end
      end
      HMON_HOT: begin
        if (fall) begin
          next_state = HMON_COOL;
        end
      end
      default: next_state = HMON_COOL;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= HMON_COOL;
      evt <= 1'b0;
    end else if (i_ce) begin
      state <= a.soft_clr ? HMON_COOL : next_state;
      evt <= next_evt && !a.soft_clr;
    end
  end

  // Acks only count while hot; a new rise starts a fresh episode
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      int_ack <= 1'b0;
      ovt_ack <= 1'b0;
    end else if (i_ce) begin
      if (a.soft_clr || rise || fall) begin
        int_ack <= 1'b0;
        ovt_ack <= 1'b0;
      end else begin
        int_ack <= int_ack || (a.int_clear && is_hot);
        ovt_ack <= ovt_ack || (a.ovt_clear && is_hot);
      end
    end
  end

  // Latched overheat: a new set wins over a same-cycle read clear
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovt_latch <= 1'b0;
    end else if (i_ce) begin
      if (a.soft_clr) begin
        ovt_latch <= 1'b0;
      end else if (rise || (fall && ovt_ack)) begin
        ovt_latch <= 1'b1;
      end else if (a.ovt_clear) begin
        ovt_latch <= 1'b0;
      end
    end
  end

  assign a.event_p = evt;
  assign a.ovt_on = a.ovt_int_mode ? ovt_latch : is_hot;

endmodule

`default_nettype wire

/* hdl/hmon_alarm_port.sv */
`default_nettype none

// Functional notes
// - Sensor 1 reads 8-bit signed; sensors 2/3 9-bit at 50h/51h bit 7.
// - Sensor 1 hysteresis of 127 selects comparator alarm mode.
// - Comparator: alarm per conversion above limit, until below limit.
// - Sensor 1 hysteresis below limit selects two-times alarm mode.
// - Two-times: alarm on rise; on fall only if first alarm read.
// - Sensors 2/3 alarm mode chosen by a bank control bit.
// - Sensors 2/3 comparator: alarm per conversion until below hysteresis.
// - Per-bank bit picks overheat mode; software keeps both copies equal.
// - Overheat comparator mode: active from over limit until below hyst.
// - Overheat interrupt mode: latch until temp read; relatch on fall if temp was read while hot.
// - Index port: 7-bit pointer, read-only busy bit 7, resets 00h.
// - Busy sets on index write or serial traffic; data access clears.
// - Data port reaches the indexed location; read data resets 00h.
// - Data access at 41h, 43h, 45h steps pointer to the pair.
// - Pointer steps in 00-1Fh and 60-7Fh, stopping at 1Fh, 7Fh.
// - Config bit 7 restores defaults except serial address, self-clears.
// - Config bit 6 drives the tone or general output low.
// - Config bit 3 masks the interrupt and halts monitoring.
// - Config bit 1 enables interrupt; bit 0 starts monitoring.
// - Two status registers latch channel violations; reading clears them.
// - Mask bit one keeps its status bit off the interrupt.
module hmon_alarm_port (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [2:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_host_rdata,
  input wire logic i_serial_busy,
  input wire logic [7:0] i_core_rdata,
  output logic o_core_wr,
  output logic [6:0] o_core_addr,
  output logic [7:0] o_core_wdata,
  output logic o_core_soft_reset,
  input wire logic [2:0] i_conv_done,
  input wire logic [7:0] i_temp1,
  input wire logic [8:0] i_temp2,
  input wire logic [8:0] i_temp3,
  input wire logic [7:0] i_t1_over,
  input wire logic [7:0] i_t1_hyst,
  input wire logic [8:0] i_t2_over,
  input wire logic [8:0] i_t2_hyst,
  input wire logic [8:0] i_t3_over,
  input wire logic [8:0] i_t3_hyst,
  input wire logic i_t23_two_times,
  input wire logic i_ovt_int_bank1,
  input wire logic i_ovt_int_bank2,
  input wire logic [2:0] i_bank,
  input wire logic i_t23_reg_read,
  input wire logic [5:0] i_limit_event1,
  input wire logic [4:0] i_limit_event2,
  input wire logic [3:0] i_vid,
  output logic o_mgmt_interrupt_n,
  output logic o_overheat_out_n,
  output logic o_tone_or_general_out_n,
  output logic o_monitor_run
);

  logic [6:0] ptr;
  logic busy_addr;
  logic [7:0] cfg;
  logic [7:0] st1;
  logic [7:0] st2;
  logic [7:0] smi_m1;
  logic [7:0] smi_m2;
  logic [7:0] nmi_m1;
  logic [7:0] nmi_m2;
  logic [3:0] fan_div;
  logic [6:0] ser_adr;

  // ==========================================================
  // Host port decode
  // ==========================================================
  wire logic sel_ix = i_host_addr == hmon_pkg::HMON_PORT_INDEX;
  wire logic sel_dat = i_host_addr == hmon_pkg::HMON_PORT_DATA;
  wire logic ix_wr = i_ce && i_host_wr && sel_ix;
  wire logic dat_wr = i_ce && i_host_wr && sel_dat;
  wire logic dat_rd = i_ce && i_host_rd && sel_dat;
  wire logic dat_acc = dat_wr || dat_rd;

  wire logic at_cfg = ptr == hmon_pkg::HMON_IX_CFG;
  wire logic at_st1 = ptr == hmon_pkg::HMON_IX_ST1;
  wire logic at_st2 = ptr == hmon_pkg::HMON_IX_ST2;
  wire logic at_smi1 = ptr == hmon_pkg::HMON_IX_SMI1;
  wire logic at_smi2 = ptr == hmon_pkg::HMON_IX_SMI2;
  wire logic at_nmi1 = ptr == hmon_pkg::HMON_IX_NMI1;
  wire logic at_nmi2 = ptr == hmon_pkg::HMON_IX_NMI2;
  wire logic at_fdiv = ptr == hmon_pkg::HMON_IX_FANDIV;
  wire logic at_sadr = ptr == hmon_pkg::HMON_IX_SERADR;
  wire logic at_t1 = ptr == hmon_pkg::HMON_IX_TEMP1;
  wire logic at_thi = ptr == hmon_pkg::HMON_IX_TEMP_HI;
  wire logic at_tlo = ptr == hmon_pkg::HMON_IX_TEMP_LO;
  wire logic own_reg = at_cfg || at_st1 || at_st2 || at_smi1 ||
                       at_smi2 || at_nmi1 || at_nmi2 || at_fdiv ||
                       at_sadr;

  // Soft reset pulse; the bit itself is never stored
  wire logic srst = dat_wr && at_cfg &&
                    i_host_wdata[hmon_pkg::HMON_CFG_SRST];
  wire logic run = cfg[hmon_pkg::HMON_CFG_START] &&
                   !cfg[hmon_pkg::HMON_CFG_HALT];

  // ==========================================================
  // Pointer stepping
  // ==========================================================
  wire logic pair_step = at_st1 || at_smi1 || at_nmi1;
  wire logic scr_step = ptr < hmon_pkg::HMON_IX_SCR_END;
  wire logic vram_step = ptr >= hmon_pkg::HMON_IX_VRAM_BEGIN &&
                         ptr < hmon_pkg::HMON_IX_VRAM_END;
  wire logic ptr_step = pair_step || scr_step || vram_step;
  wire logic [6:0] ptr_inc = ptr + 7'h01;

  // ==========================================================
  // Read selection
  // ==========================================================
  wire logic t2_sel = i_bank == hmon_pkg::HMON_BANK_T2;
  wire logic [8:0] t23 = t2_sel ? i_temp2 : i_temp3;
  wire logic busy_view = busy_addr || i_serial_busy;
  wire logic [7:0] ix_view = {busy_view, ptr};
  wire logic [7:0] dat_view =
    at_cfg ? cfg :
    at_st1 ? st1 :
    at_st2 ? st2 :
    at_smi1 ? smi_m1 :
    at_smi2 ? smi_m2 :
    at_nmi1 ? nmi_m1 :
    at_nmi2 ? nmi_m2 :
    at_fdiv ? {fan_div, i_vid} :
    at_sadr ? {1'b0, ser_adr} :
    at_t1 ? i_temp1 :
    at_thi ? t23[8:1] :
    at_tlo ? {t23[0], 7'h00} :
    i_core_rdata;
  wire logic [7:0] rd_mux = sel_ix ? ix_view :
                            sel_dat ? dat_view :
                            hmon_pkg::HMON_RST_ZERO;

  // ==========================================================
  // Temperature alarms, one lane per sensor
  // ==========================================================
  wire logic signed [8:0] temp9 [3];
  wire logic signed [8:0] over9 [3];
  wire logic signed [8:0] hyst9 [3];
  wire logic [2:0] mode2x;
  wire logic [2:0] rel_over;
  wire logic [2:0] ovt_mode;
  wire logic [2:0] clr_int;
  logic [2:0] evt;
  logic [2:0] ovt;

  // Sensor 1 is scaled to half degrees so all lanes share one width
  assign temp9[0] = {i_temp1, 1'b0};
  assign over9[0] = {i_t1_over, 1'b0};
  assign hyst9[0] = {i_t1_hyst, 1'b0};
  assign temp9[1] = i_temp2;
  assign over9[1] = i_t2_over;
  assign hyst9[1] = i_t2_hyst;
  assign temp9[2] = i_temp3;
  assign over9[2] = i_t3_over;
  assign hyst9[2] = i_t3_hyst;

  wire logic t1_cmp = i_t1_hyst == hmon_pkg::HMON_CMP_HYST;
  assign rel_over = {2'b00, t1_cmp};
  assign mode2x = {i_t23_two_times, i_t23_two_times, !t1_cmp};
  assign ovt_mode = {i_ovt_int_bank2, i_ovt_int_bank1, 1'b0};
  assign clr_int = {dat_rd && at_st2, dat_rd && at_st1,
                    dat_rd && at_st1};
  wire logic ovt_clr = i_t23_reg_read ||
                       (dat_rd && (at_thi || at_tlo));

  hmon_alarm_if #(.W(9)) alm [3] ();

  for (genvar g = 0; g < 3; g++) begin : g_lane
    assign alm[g].temp = temp9[g];
    assign alm[g].over = over9[g];
    assign alm[g].hyst = hyst9[g];
    assign alm[g].conv = i_conv_done[g] && run;
    assign alm[g].rel_at_over = rel_over[g];
    assign alm[g].two_times = mode2x[g];
    assign alm[g].ovt_int_mode = ovt_mode[g];
    assign alm[g].int_clear = clr_int[g];
    assign alm[g].ovt_clear = ovt_clr;
    assign alm[g].soft_clr = srst;
    assign evt[g] = alm[g].event_p;
    assign ovt[g] = alm[g].ovt_on;

    hmon_temp_alarm #(
      .W(9)
    ) u_alarm (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .a(alm[g])
    );
  end

  // ==========================================================
  // Status set terms
  // ==========================================================
  wire logic [7:0] st1_set =
    {i_limit_event1[5:4], 2'b00, i_limit_event1[3:0]} |
    (8'(evt[0]) << hmon_pkg::HMON_ST1_T1) |
    (8'(evt[1]) << hmon_pkg::HMON_ST1_T2);
  wire logic [7:0] st2_set =
    {3'b000, i_limit_event2} |
    (8'(evt[2]) << hmon_pkg::HMON_ST2_T3);
  wire logic [7:0] st1_gate = run ? st1_set : hmon_pkg::HMON_RST_ZERO;
  wire logic [7:0] st2_gate = run ? st2_set : hmon_pkg::HMON_RST_ZERO;
  wire logic [7:0] st1_keep = (dat_rd && at_st1) ? 8'h00 : st1;
  wire logic [7:0] st2_keep = (dat_rd && at_st2) ? 8'h00 : st2;
  wire logic smi_any = |(st1 & ~smi_m1) || |(st2 & ~smi_m2);
  wire logic smi_on = cfg[hmon_pkg::HMON_CFG_SMIEN] &&
                      !cfg[hmon_pkg::HMON_CFG_HALT] && smi_any;

  // ==========================================================
  // Index port and busy
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr <= 7'h00;
      busy_addr <= 1'b0;
    end else if (ix_wr) begin
      ptr <= i_host_wdata[6:0];
      busy_addr <= 1'b1;
    end else if (dat_acc) begin
      busy_addr <= 1'b0;
      if (ptr_step) begin
        ptr <= ptr_inc;
      end
    end
  end

  // Host read result from any port; holds between reads
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_host_rdata <= hmon_pkg::HMON_RST_ZERO;
    end else if (i_ce && i_host_rd) begin
      o_host_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // Forwarding to the monitor core
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_core_wr <= 1'b0;
      o_core_addr <= 7'h00;
      o_core_wdata <= hmon_pkg::HMON_RST_ZERO;
      o_core_soft_reset <= 1'b0;
    end else if (i_ce) begin
      o_core_wr <= dat_wr && !own_reg;
      o_core_soft_reset <= srst;
      if (dat_wr) begin
        o_core_addr <= ptr;
        o_core_wdata <= i_host_wdata;
      end
    end
  end

  // ==========================================================
  // Configuration and masks
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg <= hmon_pkg::HMON_RST_CFG;
      smi_m1 <= hmon_pkg::HMON_RST_ZERO;
      smi_m2 <= hmon_pkg::HMON_RST_ZERO;
      nmi_m1 <= hmon_pkg::HMON_RST_ZERO;
      nmi_m2 <= hmon_pkg::HMON_RST_NMI2;
      fan_div <= hmon_pkg::HMON_RST_FANDIV;
    end else if (srst) begin
      cfg <= hmon_pkg::HMON_RST_CFG;
      smi_m1 <= hmon_pkg::HMON_RST_ZERO;
      smi_m2 <= hmon_pkg::HMON_RST_ZERO;
      nmi_m1 <= hmon_pkg::HMON_RST_ZERO;
      nmi_m2 <= hmon_pkg::HMON_RST_NMI2;
      fan_div <= hmon_pkg::HMON_RST_FANDIV;
    end else if (dat_wr) begin
      if (at_cfg) begin
        cfg <= {1'b0, i_host_wdata[6:0]};
      end
      if (at_smi1) begin
        smi_m1 <= i_host_wdata;
      end
      if (at_smi2) begin
        smi_m2 <= i_host_wdata;
      end
      if (at_nmi1) begin
        nmi_m1 <= i_host_wdata;
      end
      if (at_nmi2) begin
        nmi_m2 <= i_host_wdata;
      end
      if (at_fdiv) begin
        fan_div <= i_host_wdata[7:4];
      end
    end
  end

  // Serial address survives the soft reset
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ser_adr <= hmon_pkg::HMON_RST_SERADR;
    end else if (dat_wr && at_sadr) begin
      ser_adr <= i_host_wdata[6:0];
    end
  end

  // ==========================================================
  // Status registers: set wins over read clear
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st1 <= hmon_pkg::HMON_RST_ZERO;
      st2 <= hmon_pkg::HMON_RST_ZERO;
    end else if (i_ce) begin
      if (srst) begin
        st1 <= hmon_pkg::HMON_RST_ZERO;
        st2 <= hmon_pkg::HMON_RST_ZERO;
      end else begin
        st1 <= st1_keep | st1_gate;
        st2 <= st2_keep | st2_gate;
      end
    end
  end

  // ==========================================================
  // Pins
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mgmt_interrupt_n <= 1'b1;
      o_overheat_out_n <= 1'b1;
      o_tone_or_general_out_n <= 1'b1;
      o_monitor_run <= 1'b0;
    end else if (i_ce) begin
      o_mgmt_interrupt_n <= !smi_on;
      o_overheat_out_n <= !(ovt[1] || ovt[2]);
      o_tone_or_general_out_n <=
        !cfg[hmon_pkg::HMON_CFG_TONE];
      o_monitor_run <= run;
    end
  end

endmodule

`default_nettype wire

/* tb/hmon_alarm_port_props.sv */
`default_nettype none

module hmon_alarm_port_props (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [2:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_wdata,
  input wire logic [7:0] o_host_rdata,
  input wire logic i_serial_busy,
  input wire logic o_core_wr,
  input wire logic [6:0] o_core_addr,
  input wire logic [7:0] o_core_wdata,
  input wire logic o_core_soft_reset,
  input wire logic [2:0] i_conv_done,
  input wire logic [8:0] i_temp2,
  input wire logic [8:0] i_t2_over,
  input wire logic i_ovt_int_bank1,
  input wire logic o_overheat_out_n,
  input wire logic o_monitor_run
);
  // ========================================
  // Host port and alarm checks
  // ========================================
  logic rd_on;
  logic wr_on;
  assign rd_on = i_ce && i_host_rd;
  assign wr_on = i_ce && i_host_wr;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  sequence ix_wr_s;
    wr_on && i_host_addr == 3'h5;
  endsequence
  sequence ix_rd_s;
    rd_on && i_host_addr == 3'h5;
  endsequence
  rdata_hold_a:
    assert property (!rd_on |=> $stable(o_host_rdata))
    else $error("read data moved without a read");
  idle_port_a:
    assert property (rd_on && !(i_host_addr inside {3'h5, 3'h6})
      |=> o_host_rdata == 8'h00)
    else $error("unused port read not zero");
  core_cause_a:
    assert property (o_core_wr |-> $past(wr_on && i_host_addr == 3'h6)
      && o_core_wdata == $past(i_host_wdata))
    else $error("core write without data write");
  core_range_a:
    assert property (o_core_wr |-> !(o_core_addr inside {[7'h40:7'h48]}))
    else $error("core write at local register");
  busy_index_a:
    assert property (ix_wr_s ##1 !(rd_on || wr_on) ##1 ix_rd_s
      |=> o_host_rdata[7]
      && o_host_rdata[6:0] == $past(i_host_wdata[6:0], 3))
    else $error("index write not seen as busy pointer");
  serial_busy_a:
    assert property (rd_on && i_host_addr == 3'h5 && i_serial_busy
      |=> o_host_rdata[7])
    else $error("serial traffic not seen as busy");
  soft_pulse_a:
    assert property (o_core_soft_reset |-> $past(wr_on
      && i_host_addr == 3'h6 && i_host_wdata[7]) ##1 !o_core_soft_reset)
    else $error("bad soft reset pulse");
  ovt_cmp_a:
    assert property (i_ce && i_conv_done[1] && o_monitor_run
      && !i_ovt_int_bank1 && $signed(i_temp2) > $signed(i_t2_over)
      |-> ##[1:3] !o_overheat_out_n)
    else $error("overheat not raised");
endmodule

bind hmon_alarm_port hmon_alarm_port_props u_props (.*);

`default_nettype wire

/* tb/hmon_core_model.sv */
`default_nettype none

// Monitor core stand-in: RAM behind the pointer the bench tracks
module hmon_core_model (
  input wire logic i_mclk,
  input wire logic i_wr,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [6:0] i_ptr,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  // Inverse of index, so a stale read never looks right
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(~i);
  always @(posedge i_mclk) if (i_wr) mem[i_addr] <= i_wdata;
  assign o_rdata = mem[i_ptr];
endmodule

`default_nettype wire

/* tb/tb_hw_monitor_alarm_and_host_port.sv */
`default_nettype none

module tb_hw_monitor_alarm_and_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_resetn, i_ce, i_host_wr, i_host_rd, i_serial_busy;
  logic [2:0] i_host_addr, i_conv_done, i_bank;
  logic [7:0] i_host_wdata, o_host_rdata, i_core_rdata, o_core_wdata, d;
  logic [7:0] i_temp1, i_t1_over, i_t1_hyst;
  logic [8:0] i_temp2, i_temp3, i_t2_over, i_t2_hyst, i_t3_over, i_t3_hyst;
  logic [6:0] o_core_addr, ptr;
  logic [5:0] i_limit_event1;
  logic [4:0] i_limit_event2;
  logic [3:0] i_vid;
  logic o_core_wr, o_core_soft_reset, i_t23_two_times, i_ovt_int_bank1;
  logic i_ovt_int_bank2, i_t23_reg_read, o_mgmt_interrupt_n;
  logic o_overheat_out_n, o_tone_or_general_out_n, o_monitor_run;
  int miscompares, n_compared;
  logic [6:0] stp [10][2] = '{'{7'h41, 7'h42}, '{7'h43, 7'h44},
    '{7'h45, 7'h46}, '{7'h00, 7'h01}, '{7'h1e, 7'h1f}, '{7'h1f, 7'h1f},
    '{7'h60, 7'h61}, '{7'h7e, 7'h7f}, '{7'h7f, 7'h7f}, '{7'h40, 7'h40}};

  hmon_alarm_port DUT (.*);
  hmon_core_model core (.i_mclk(i_mclk), .i_wr(o_core_wr),
    .i_addr(o_core_addr), .i_wdata(o_core_wdata), .i_ptr(ptr),
    .o_rdata(i_core_rdata));

  initial begin
    i_mclk = 0;
    forever #4 i_mclk = ~i_mclk;
  end

  // ========================================
  // Host access helpers
  // ========================================
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Entered just after an edge; leaves just after an edge
  task automatic acc(logic rd, logic [2:0] a, logic [7:0] w);
    {i_host_addr, i_host_wdata, i_host_rd, i_host_wr} = {a, w, rd, !rd};
    @(posedge i_mclk);
    #1;
    d = o_host_rdata;
    {i_host_rd, i_host_wr} = 0;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic wreg(logic [6:0] ix, logic [7:0] v);
    acc(0, hmon_pkg::HMON_PORT_INDEX, {1'b0, ix});
    acc(0, hmon_pkg::HMON_PORT_DATA, v);
  endtask
  task automatic rreg(logic [6:0] ix, logic [7:0] e, string n);
    ptr = ix;
    acc(0, hmon_pkg::HMON_PORT_INDEX, {1'b0, ix});
    acc(1, hmon_pkg::HMON_PORT_DATA, 8'h00);
    chk(n, e, d);
  endtask
  // Conversion pulse, then enough cycles for the outputs to settle
  task automatic conv(logic [2:0] b);
    i_conv_done = b;
    @(posedge i_mclk);
    #1;
    i_conv_done = 0;
    repeat (4) @(posedge i_mclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100us;
    miscompares++;
    wrap_up;
  end

  // ========================================
  // Tests
  // ========================================
  initial begin
    {i_resetn, i_host_wr, i_host_rd, i_serial_busy, i_conv_done} = 0;
    {i_host_addr, i_host_wdata, i_bank, ptr, i_temp3} = 0;
    {i_limit_event1, i_limit_event2, i_t23_reg_read, i_t23_two_times} = 0;
    {i_ovt_int_bank1, i_ovt_int_bank2, i_ce, i_vid} = {3'b001, 4'ha};
    {i_temp1, i_t1_over, i_t1_hyst} = {8'h40, 8'h30, 8'h7f};
    {i_temp2, i_t2_over, i_t2_hyst} = {9'h033, 9'h060, 9'h040};
    {i_t3_over, i_t3_hyst} = {9'h0f0, 9'h0e0};
    repeat (10) @(posedge i_mclk);
    #1;
    i_resetn = 1;
    acc(1, 3'h5, 0);
    chk("index port", 8'h00, d);
    acc(0, 3'h5, 8'h41);
    acc(1, 3'h5, 0);
    chk("busy after index write", 8'hc1, d);
    acc(1, 3'h6, 0);
    acc(1, 3'h5, 0);
    chk("busy after data read", 8'h42, d);
    i_serial_busy = 1;
    acc(1, 3'h5, 0);
    chk("serial busy", 8'hc2, d);
    i_serial_busy = 0;
    acc(1, 3'h3, 0);
    chk("unused port", 8'h00, d);
    foreach (stp[i]) begin
      acc(0, 3'h5, {1'b0, stp[i][0]});
      acc(1, 3'h6, 0);
      acc(1, 3'h5, 0);
      chk("pointer step", {1'b0, stp[i][1]}, d);
    end
    wreg(7'h10, 8'ha5);
    rreg(7'h10, 8'ha5, "scratch ram");
    rreg(7'h40, 8'h01, "config reset");
    rreg(7'h46, 8'h20, "mask reset");
    rreg(7'h47, 8'h5a, "divisor and id");
    wreg(7'h40, 8'h03);
    conv(3'b001);
    chk("interrupt", 8'h00, {7'h0, o_mgmt_interrupt_n});
    rreg(7'h41, 8'h10, "status one");
    conv(3'b000);
    chk("interrupt cleared", 8'h01, {7'h0, o_mgmt_interrupt_n});
    conv(3'b001);
    chk("interrupt again", 8'h00, {7'h0, o_mgmt_interrupt_n});
    wreg(7'h43, 8'h10);
    conv(3'b000);
    chk("masked", 8'h01, {7'h0, o_mgmt_interrupt_n});
    wreg(7'h43, 8'h00);
    wreg(7'h40, 8'h0b);
    conv(3'b000);
    chk("halted", 8'h01, {7'h0, o_mgmt_interrupt_n});
    chk("halted run", 8'h00, {7'h0, o_monitor_run});
    wreg(7'h40, 8'h03);
    conv(3'b000);
    chk("resumed", 8'h00, {7'h0, o_mgmt_interrupt_n});
    rreg(7'h41, 8'h10, "status kept");
    i_temp1 = 8'h20;
    conv(3'b001);
    rreg(7'h41, 8'h00, "cool");
    {i_limit_event1, i_limit_event2} = {6'h20, 5'h01};
    @(posedge i_mclk);
    #1;
    {i_limit_event1, i_limit_event2} = 0;
    rreg(7'h41, 8'h80, "status one event");
    acc(1, 3'h6, 0);
    chk("status two", 8'h01, d);
    {i_t1_hyst, i_temp1} = {8'h10, 8'h40};
    conv(3'b001);
    rreg(7'h41, 8'h10, "two times rise");
    conv(3'b001);
    rreg(7'h41, 8'h00, "two times hot");
    i_temp1 = 8'h00;
    conv(3'b001);
    rreg(7'h41, 8'h10, "two times fall");
    i_temp2 = 9'h080;
    conv(3'b010);
    chk("overheat on", 8'h00, {7'h0, o_overheat_out_n});
    i_temp2 = 9'h050;
    conv(3'b010);
    chk("overheat held", 8'h00, {7'h0, o_overheat_out_n});
    i_temp2 = 9'h033;
    conv(3'b010);
    chk("overheat off", 8'h01, {7'h0, o_overheat_out_n});
    i_bank = 3'h1;
    rreg(7'h50, 8'h19, "temp high");
    rreg(7'h51, 8'h80, "temp low bit");
    rreg(7'h27, 8'h00, "temp one");
    wreg(7'h40, 8'h43);
    conv(3'b000);
    chk("tone", 8'h00, {7'h0, o_tone_or_general_out_n});
    wreg(7'h43, 8'h55);
    wreg(7'h40, 8'h80);
    rreg(7'h40, 8'h01, "soft reset config");
    rreg(7'h43, 8'h00, "soft reset mask");
    i_ce = 0;
    acc(0, 3'h5, 8'h10);
    i_ce = 1;
    acc(1, 3'h5, 0);
    chk("frozen index", 8'h44, d);
    {i_ovt_int_bank1, i_ovt_int_bank2, i_t23_two_times} = 3'b111;
    i_temp2 = 9'h080;
    conv(3'b010);
    chk("latch on", 8'h00, {7'h0, o_overheat_out_n});
    rreg(7'h41, 8'h20, "two rise");
    chk("latch held", 8'h00, {7'h0, o_overheat_out_n});
    rreg(7'h50, 8'h40, "temp hot");
    chk("latch clear", 8'h01, {7'h0, o_overheat_out_n});
    i_temp2 = 9'h030;
    conv(3'b010);
    chk("latch again", 8'h00, {7'h0, o_overheat_out_n});
    rreg(7'h41, 8'h20, "two fall");
    wrap_up;
  end
endmodule

`default_nettype wire
